/* File: hw/spindle_ctrl_pkg.sv */
// package for the spindle speed control serial port: control word layout,
// pin carriers, loop states and reset values.
// assumes a 100 MHz core clock and a separate serial port clock from the host.
package spindle_ctrl_pkg;

	// ----------------------------------------------------------------
	// control word layout
	// ----------------------------------------------------------------
	localparam int                 CW_W             = 24;
	localparam logic [CW_W-1:0]    CW_RESET         = 24'h00_0000;
	localparam int                 RUN_POS          = 0;
	localparam int                 STEP_POS         = 1;
	localparam int                 BRAKE_POS        = 2;
	localparam int                 ILIM_POS         = 3;
	localparam int                 REF_POS          = 5;
	localparam int                 REF_BITS         = 14;
	localparam int                 REF_WEIGHT_SHIFT = 4;
	localparam int                 REF_W            = 18;
	localparam int                 SRC_POS          = 19;
	localparam int                 POLE_POS         = 20;
	localparam int                 DIAG_POS         = 22;

	// ----------------------------------------------------------------
	// pole and diagnostic encodings
	// ----------------------------------------------------------------
	localparam int                 POLE_W           = 5;
	localparam logic [1:0]         POLE_CODE_16     = 2'h2;
	localparam logic [1:0]         POLE_CODE_12     = 2'h3;
	localparam logic [POLE_W-1:0]  POLES_8          = 5'h08;
	localparam logic [POLE_W-1:0]  POLES_12         = 5'h0c;
	localparam logic [POLE_W-1:0]  POLES_16         = 5'h10;
	localparam logic [1:0]         DIAG_TICK        = 2'h0;
	localparam logic [1:0]         DIAG_THERMAL     = 2'h1;
	localparam logic [1:0]         DIAG_SYNC        = 2'h2;
	localparam logic [1:0]         DIAG_ZERO_CROSS  = 2'h3;
	localparam logic [2:0]         ALL_ON           = 3'h7;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic chip_sel_n;
		logic reset_n;
		logic brake_n;
		logic sector;
		logic counter_timebase_clock;
		logic zero_cross_detect;
		logic thermal;
		logic bemf_step;
		logic startup_step;
	} pin_in_t;

	localparam int      PIN_W    = $bits(pin_in_t);
	localparam pin_in_t PIN_IDLE = '{chip_sel_n: 1'b1, reset_n: 1'b1, brake_n: 1'b1, default: 1'b0};

	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} drive_t;

	typedef enum logic [1:0] {LOOP_IDLE, LOOP_WINDOW, LOOP_FAST, LOOP_SLOW} loop_state_t;

	typedef struct packed {
		logic [CW_W-1:0] shift;
	} link_state_t;

	typedef struct packed {
		logic [PIN_W-1:0]  s1;
		logic [PIN_W-1:0]  s2;
		logic [PIN_W-1:0]  s3;
		logic [PIN_W-1:0]  filt;
		logic [CW_W-1:0]   control_word;
		logic              brake_latched;
		logic              zero_cross_toggle;
		logic [POLE_W-1:0] zc_count;
		logic              tick_int;
		logic              tick_prev;
		loop_state_t       loop;
		logic [REF_W-1:0]  window_count;
		logic              startup_clamp;
		logic              err_fast;
		logic              err_slow;
		logic              commutate;
		logic              diag;
		drive_t            drive;
	} core_state_t;

	localparam core_state_t CORE_RESET = '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, filt: PIN_IDLE,
		control_word: CW_RESET, startup_clamp: 1'b1, loop: LOOP_IDLE, default: '0};

endpackage

/* File: hw/spindle_speed_control_serial_port.sv */
// spindle speed control serial port: 24-bit write-only control word, brake,
// drive gating, revolution tick and frequency-locked speed loop.
// assumes: serial clock idles low outside frames, analog inputs arrive
// asynchronously, the commutation sequencer supplies phase commands on clk_in.
//
// Contract
// [R1] chip select high: serial data and clock ignored, shift register unchanged
// [R2] host holds serial clock low before pulling chip select low
// [R3] chip select low: shift serial data into 24-bit register on clock rise
// [R4] rising chip select latches the shifted word; settings take effect then
// [R5] run bit is shifted last; bit 23 goes first
// [R6] run bit 0 puts device to sleep, 1 runs it
// [R7] step-only bit: only startup oscillator commutates, back-EMF path disabled
// [R8] brake bit or low brake input applies brake
// [R9] braking: all high sides off, all low sides on
// [R10] once braking, low sides stay on until reset
// [R11] two bits select current limit: saturated, 1 A, 800 mA, 600 mA
// [R12] reference count: sum of weights of 14 low-programmed bits, 16 to 131072
// [R13] tick rising edge starts reference window of programmed timebase cycles
// [R14] error from tick and window falling edges drives correcting charge pump
// [R15] internal mode counts zero-cross toggles; tick toggles once per revolution
// [R16] pole bits set counter: 00 eight, 10 sixteen, 11 twelve, 01 undefined
// [R17] speed source bit selects internal tick or external sector pulse
// [R18] output select routes tick, thermal, loop phase or zero-cross toggle
// [R19] host switches to sector source only while loop phase flag low
// [R20] startup clamp on at startup, released on first error-fast event
// [R21] low reset input clears all control bits, device sleeps
// [R22] zero-cross toggle changes state at every detected zero crossing
// [R23] tick falling before window end flags error-fast, otherwise error-slow
`timescale 1ns/1ps
module spindle_speed_control_serial_port
	import spindle_ctrl_pkg::*;
(
	// core clock and reset
	input  wire logic          clk_in,
	input  wire logic          sys_rst_in,
	// serial port link
	input  wire logic          serial_clk_in,
	input  wire logic          ser_data_in,
	// asynchronous pins
	input  wire pin_in_t       async_pins_in,
	// commutation sequencer
	input  wire drive_t        phase_cmd_in,
	// motor drivers and commutation
	output drive_t             drive_out,
	output logic               commutate_out,
	// control settings
	output logic               run_out,
	output logic               step_only_out,
	output logic [1:0]         current_limit_out,
	// speed loop
	output logic               startup_clamp_out,
	output logic               pump_up_out,
	output logic               pump_down_out,
	output logic               err_fast_out,
	output logic               err_slow_out,
	// diagnostics
	output logic               diag_out
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [REF_W-1:0] ref_total(input logic [CW_W-1:0] cw);
		logic [REF_W-1:0] sum;
		sum = '0;
		for (int i = 0; i < REF_BITS; i++) begin
			if (!cw[REF_POS+i]) begin
				sum = sum + (REF_W'(1) << (i + REF_WEIGHT_SHIFT)); // [R12]
			end
		end
		return sum;
	endfunction

	function automatic logic [POLE_W-1:0] pole_limit(input logic [1:0] code);
		case (code)
			POLE_CODE_16: return POLES_16; // [R16]
			POLE_CODE_12: return POLES_12; // [R16]
			default:      return POLES_8;  // [R16]
		endcase
	endfunction

	// ----------------------------------------------------------------
	// serial link domain
	// ----------------------------------------------------------------
	link_state_t link_reg;
	link_state_t link_next;

	// chip select is set up against the idle-low serial clock by the host
	always_comb begin // [R2]
		link_next = link_reg;
		if (!async_pins_in.chip_sel_n) begin // [R1]
			link_next.shift = {link_reg.shift[CW_W-2:0], ser_data_in}; // [R3] [R5]
		end
	end

	always_ff @(posedge serial_clk_in) begin
		link_reg <= link_next;
	end

	a_shift_bit_in: assert property (@(posedge serial_clk_in) // [R3]
		!async_pins_in.chip_sel_n |=> link_reg.shift[0] == $past(ser_data_in))
		else $error("serial bit not shifted in");

	a_link_hold: assert property (@(posedge serial_clk_in) // [R1]
		async_pins_in.chip_sel_n |=> $stable(link_reg.shift))
		else $error("shift register changed while deselected");

	// ----------------------------------------------------------------
	// core domain
	// ----------------------------------------------------------------
	core_state_t          st_reg;
	core_state_t          st_next;
	pin_in_t              f;
	pin_in_t              p;
	logic [PIN_W-1:0]     diff;
	logic [CW_W-1:0]      cw;
	logic                 dev_reset;
	logic                 run;
	logic                 cs_rise;
	logic                 zc_event;
	logic [POLE_W-1:0]    zc_inc;
	logic [POLE_W-1:0]    pole_lim;
	logic                 tick;
	logic                 tick_rise;
	logic                 tick_fall;
	logic                 tb_rise;
	logic                 window_end;
	logic [REF_W-1:0]     ref_count;
	logic [REF_W-1:0]     count_dec;
	logic                 brake_req;
	logic                 bemf_rise;
	logic                 start_rise;

	always_comb begin
		st_next = st_reg;
		// pins pass three stages; a level counts once stages two and three agree
		st_next.s1   = async_pins_in;
		st_next.s2   = st_reg.s1;
		st_next.s3   = st_reg.s2;
		diff         = st_reg.s2 ^ st_reg.s3;
		st_next.filt = (st_reg.s2 & ~diff) | (st_reg.filt & diff);
		f            = pin_in_t'(st_next.filt);
		p            = pin_in_t'(st_reg.filt);
		cw           = st_reg.control_word;
		run          = cw[RUN_POS];
		dev_reset    = !f.reset_n;
		cs_rise      = f.chip_sel_n && !p.chip_sel_n;
		zc_event     = f.zero_cross_detect && !p.zero_cross_detect;
		zc_inc       = st_reg.zc_count + 5'h01;
		pole_lim     = pole_limit({cw[POLE_POS], cw[POLE_POS+1]});
		tick         = cw[SRC_POS] ? f.sector : st_reg.tick_int; // [R17]
		tick_rise    = tick && !st_reg.tick_prev;
		tick_fall    = !tick && st_reg.tick_prev;
		tb_rise      = f.counter_timebase_clock && !p.counter_timebase_clock;
		ref_count    = ref_total(cw); // [R12]
		count_dec    = tb_rise ? st_reg.window_count - 18'h0_0001 : st_reg.window_count;
		window_end   = tb_rise && (st_reg.window_count == 18'h0_0001);
		brake_req    = cw[BRAKE_POS] || !f.brake_n;
		bemf_rise    = f.bemf_step && !p.bemf_step;
		start_rise   = f.startup_step && !p.startup_step;

		st_next.err_fast  = 1'b0;
		st_next.err_slow  = 1'b0;
		st_next.tick_prev = tick;

		// shifted word is stable here: the serial clock has stopped with chip select high
		if (cs_rise) begin
			st_next.control_word = link_reg.shift; // [R4]
		end

		// zero-cross toggle and once-per-revolution tick
		if (zc_event) begin
			st_next.zero_cross_toggle = !st_reg.zero_cross_toggle; // [R22]
			if (zc_inc >= pole_lim) begin
				st_next.zc_count = '0;
				st_next.tick_int = !st_reg.tick_int; // [R15]
			end else begin
				st_next.zc_count = zc_inc; // [R15]
			end
		end

		// speed loop: window against tick, error from falling edges
		if (!run) begin
			st_next.loop         = LOOP_IDLE; // [R6]
			st_next.window_count = '0;
		end else begin
			case (st_reg.loop)
				LOOP_IDLE: begin
					if (tick_rise) begin
						st_next.window_count = ref_count; // [R13]
						st_next.loop = (ref_count == '0) ? LOOP_SLOW : LOOP_WINDOW;
					end
				end
				LOOP_WINDOW: begin
					st_next.window_count = count_dec; // [R13]
					if (tick_fall && !window_end) begin
						st_next.err_fast = 1'b1; // [R23]
						st_next.loop     = LOOP_FAST; // [R14]
					end else if (tick_fall) begin
						st_next.err_slow = 1'b1; // [R23]
						st_next.loop     = LOOP_IDLE;
					end else if (window_end) begin
						st_next.loop = LOOP_SLOW; // [R14]
					end
				end
				LOOP_FAST: begin
					st_next.window_count = count_dec;
					if (tick_rise) begin
						st_next.window_count = ref_count; // [R13]
						st_next.loop = (ref_count == '0) ? LOOP_SLOW : LOOP_WINDOW;
					end else if (window_end) begin
						st_next.loop = LOOP_IDLE; // [R14]
					end
				end
				LOOP_SLOW: begin
					if (tick_fall) begin
						st_next.err_slow = 1'b1; // [R23]
						st_next.loop     = LOOP_IDLE; // [R14]
					end
				end
				default: begin
					st_next.loop = LOOP_IDLE;
				end
			endcase
		end

		// startup clamp: held in sleep, dropped on the first error-fast
		if (!run) begin
			st_next.startup_clamp = 1'b1; // [R20]
		end else if (st_next.err_fast) begin
			st_next.startup_clamp = 1'b0; // [R20]
		end

		// brake latches: the input node holds its charge until reset
		if (brake_req) begin
			st_next.brake_latched = 1'b1; // [R8] [R10]
		end

		if (st_reg.brake_latched) begin
			st_next.drive = '{high: 3'h0, low: ALL_ON}; // [R9]
		end else if (!run) begin
			st_next.drive = '0; // [R6]
		end else begin
			st_next.drive = phase_cmd_in;
		end

		// commutation advance; step-only mode ignores back-EMF
		if (!run || st_reg.brake_latched) begin
			st_next.commutate = 1'b0;
		end else if (cw[STEP_POS]) begin
			st_next.commutate = start_rise; // [R7]
		end else begin
			st_next.commutate = start_rise || bemf_rise; // [R7]
		end

		case ({cw[DIAG_POS], cw[DIAG_POS+1]})
			DIAG_TICK:       st_next.diag = tick; // [R18]
			DIAG_THERMAL:    st_next.diag = f.thermal; // [R18]
			DIAG_SYNC:       st_next.diag = (st_reg.loop == LOOP_WINDOW) || (st_reg.loop == LOOP_FAST); // [R18]
			DIAG_ZERO_CROSS: st_next.diag = st_reg.zero_cross_toggle; // [R18]
			default:         st_next.diag = 1'b0;
		endcase

		if (dev_reset) begin
			st_next.control_word  = CW_RESET; // [R21]
			st_next.brake_latched = 1'b0; // [R10]
			st_next.loop          = LOOP_IDLE;
			st_next.window_count  = '0;
			st_next.startup_clamp = 1'b1;
			st_next.zc_count      = '0;
			st_next.tick_int      = 1'b0;
			st_next.err_fast      = 1'b0;
			st_next.err_slow      = 1'b0;
			st_next.commutate     = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st_reg <= CORE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign drive_out         = st_reg.drive;
	assign commutate_out     = st_reg.commutate;
	assign run_out           = st_reg.control_word[RUN_POS]; // [R6]
	assign step_only_out     = st_reg.control_word[STEP_POS];
	assign current_limit_out = {st_reg.control_word[ILIM_POS], st_reg.control_word[ILIM_POS+1]}; // [R11]
	assign startup_clamp_out = st_reg.startup_clamp;
	assign pump_up_out       = (st_reg.loop == LOOP_SLOW); // [R14]
	assign pump_down_out     = (st_reg.loop == LOOP_FAST); // [R14]
	assign err_fast_out      = st_reg.err_fast;
	assign err_slow_out      = st_reg.err_slow;
	assign diag_out          = st_reg.diag;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_word_latch: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R4]
		(cs_rise && !dev_reset) |=> st_reg.control_word == $past(link_reg.shift))
		else $error("control word not latched on chip select rise");

	a_reset_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R21]
		dev_reset |=> (st_reg.control_word == CW_RESET) && !run_out)
		else $error("reset pin did not clear control word");

	a_sleep_drive: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R6]
		(!run_out && !st_reg.brake_latched) |=> (drive_out == '0) && !commutate_out)
		else $error("drivers active in sleep");

	a_brake_request: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R8]
		(brake_req && !dev_reset) |=> st_reg.brake_latched)
		else $error("brake request not latched");

	a_brake_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R10]
		(st_reg.brake_latched && !dev_reset) |=> st_reg.brake_latched ##1 (drive_out.low == ALL_ON))
		else $error("brake released without reset");

	a_brake_drive: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R9]
		st_reg.brake_latched |=> (drive_out.high == 3'h0) && (drive_out.low == ALL_ON))
		else $error("brake drive pattern wrong");

	a_step_only: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R7]
		(run && cw[STEP_POS] && bemf_rise && !start_rise && !dev_reset) |=> !commutate_out)
		else $error("back-EMF commutated in step-only mode");

	a_window_load: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R13]
		(st_reg.loop == LOOP_IDLE && run && tick_rise && ref_count != '0 && !dev_reset)
		|=> (st_reg.loop == LOOP_WINDOW) && (st_reg.window_count == $past(ref_count)))
		else $error("reference window not started");

	a_fast_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R23]
		(st_reg.loop == LOOP_WINDOW && run && tick_fall && !window_end && !dev_reset)
		|=> err_fast_out && pump_down_out && !err_slow_out)
		else $error("error-fast not flagged");

	a_clamp_release: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R20]
		err_fast_out |-> !startup_clamp_out)
		else $error("startup clamp held after error-fast");

	a_tick_toggle: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R15]
		(zc_event && zc_inc >= pole_lim && !dev_reset) |=> st_reg.tick_int != $past(st_reg.tick_int))
		else $error("revolution tick did not toggle");

	a_diag_route: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R18]
		({cw[DIAG_POS], cw[DIAG_POS+1]} == DIAG_ZERO_CROSS) |=> diag_out == $past(st_reg.zero_cross_toggle))
		else $error("diagnostic output misrouted");

	a_slow_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R23]
		(st_reg.loop == LOOP_SLOW && run && tick_fall && !dev_reset)
		|=> err_slow_out && !err_fast_out && !pump_up_out)
		else $error("error-slow not flagged");

	a_window_expire: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R14]
		(st_reg.loop == LOOP_WINDOW && run && window_end && !tick_fall && !dev_reset)
		|=> pump_up_out && !pump_down_out)
		else $error("pump up not raised at window end");

	a_clamp_sleep: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R20]
		!run |=> startup_clamp_out)
		else $error("startup clamp not held in sleep");

	a_drive_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R6]
		(run && !st_reg.brake_latched) |=> drive_out == $past(phase_cmd_in))
		else $error("drivers do not follow phase command");

endmodule

/* File: testbench/spindle_host_model.sv */
// host model that writes the serial control port of the spindle block.
// assumes the bench calls its tasks by hierarchical name; the serial clock has
// a 64 ns period, free in phase, and stands low outside frames except while noise() toggles it.
`timescale 1ns/1ps
module spindle_host_model (
	// serial port pins
	output logic csn_out,
	output logic sclk_out,
	output logic sdata_out
);
	initial begin
		csn_out = 1'b1;
		sclk_out = 1'b0;
		sdata_out = 1'b0;
	end

	// shift the low n bits of w, msb first, so the run bit goes last
	task automatic send(input logic [23:0] w, input int n);
		sclk_out = 1'b0;
		#7 csn_out = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			#16 sdata_out = w[i];
			#16 sclk_out = 1'b1;
			#32 sclk_out = 1'b0;
		end
		#16 csn_out = 1'b1;
		sdata_out = ~sdata_out;
		#100;
	endtask

	// clock edges and data changes while deselected
	task automatic noise();
		for (int i = 0; i < 8; i++) begin
			#32 sclk_out = 1'b1;
			sdata_out = 1'b1;
			#32 sclk_out = 1'b0;
		end
		sdata_out = 1'b0;
		#100;
	endtask
endmodule

/* File: testbench/test_spindle_speed_control_serial_port.sv */
// self-checking bench for the spindle speed control serial port.
// assumes the design package and the host model in spindle_host_model.sv.
`timescale 1ns/1ps
module test_spindle_speed_control_serial_port
	import spindle_ctrl_pkg::*;
;
	logic        clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	pin_in_t     pins = PIN_IDLE;
	pin_in_t     pins_all;
	drive_t      phase_cmd = '0;
	drive_t      drive_out;
	logic        csn, sclk, sdata, commutate_out, run_out, step_only_out, startup_clamp_out;
	logic        pump_up_out, pump_down_out, err_fast_out, err_slow_out, diag_out;
	logic [1:0]  current_limit_out;
	logic [1:0]  pc [3] = '{2'h0, POLE_CODE_16, POLE_CODE_12};
	int          np [3] = '{8, 16, 12};
	int          bad_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          nh;
	logic [23:0] wa;
	logic        tb_clk = 1'b0;

	always #5 clk_in = ~clk_in;

	always_comb begin
		pins_all = pins;
		pins_all.chip_sel_n = csn;
		pins_all.counter_timebase_clock = tb_clk;
	end

	// timebase at a tenth of the core clock, plus the hang limit
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc % 5 == 4) begin
			#1 tb_clk = ~tb_clk;
		end
		if (cyc == 30000) begin
			bad_count++;
			summarize();
		end
	end

	spindle_speed_control_serial_port spindle_speed_control_serial_port_i (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .serial_clk_in(sclk), .ser_data_in(sdata),
		.async_pins_in(pins_all), .phase_cmd_in(phase_cmd), .drive_out(drive_out),
		.commutate_out(commutate_out), .run_out(run_out), .step_only_out(step_only_out),
		.current_limit_out(current_limit_out), .startup_clamp_out(startup_clamp_out),
		.pump_up_out(pump_up_out), .pump_down_out(pump_down_out), .err_fast_out(err_fast_out),
		.err_slow_out(err_slow_out), .diag_out(diag_out));

	spindle_host_model spindle_host_model_i (.csn_out(csn), .sclk_out(sclk), .sdata_out(sdata));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [23:0] mk(input logic run, input logic step, input logic brk, input logic [1:0] il,
		input logic [13:0] rf, input logic src, input logic [1:0] pole, input logic [1:0] dg);
		return {dg[0], dg[1], pole[0], pole[1], src, rf, il[0], il[1], brk, step, run};
	endfunction

	function automatic logic sel(input int k);
		case (k)
			0: return commutate_out;
			1: return err_fast_out;
			default: return err_slow_out;
		endcase
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [23:0] w, input int n);
		spindle_host_model_i.send(w, n);
		tick(6);
	endtask

	task automatic cnt(input int k, input int n, output int hits);
		hits = 0;
		repeat (n) begin
			tick(1);
			if (sel(k) === 1'b1) hits++;
		end
	endtask

	task automatic zc(input int n);
		repeat (n) begin
			pins.zero_cross_detect = 1'b1;
			tick(5);
			pins.zero_cross_detect = 1'b0;
			tick(5);
		end
	endtask

	task automatic rst();
		sys_rst_in = 1'b1;
		tick(5);
		sys_rst_in = 1'b0;
		tick(2);
	endtask

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		rst();
		chk(run_out, 24'h00_0000);
		chk(startup_clamp_out, 24'h00_0001);
		for (int i = 0; i < 4; i++) begin
			wr(mk(1'b1, i[0], 1'b0, i[1:0], 14'h3fff, 1'b0, 2'h0, 2'h0), 24);
			chk(current_limit_out, i[1:0]);
			chk(step_only_out, i[0]);
			chk(run_out, 24'h00_0001);
		end
		phase_cmd = '{high: 3'h5, low: 3'h2};
		wr(mk(1'b0, 1'b0, 1'b0, 2'h0, 14'h3fff, 1'b0, 2'h0, 2'h0), 24);
		chk(run_out, 24'h00_0000);
		chk(drive_out, 24'h00_0000);
		$display("test control bits done");
		wa = mk(1'b1, 1'b0, 1'b0, 2'h2, 14'h3fff, 1'b0, 2'h0, 2'h0);
		wr(wa, 24);
		chk(drive_out, 24'h00_002a);
		spindle_host_model_i.noise();
		wr(24'h00_0001, 1);
		chk(step_only_out, 24'h00_0001);
		chk(current_limit_out, 24'h00_0001);
		$display("test deselected clocks done");
		pins.brake_n = 1'b0;
		tick(4);
		pins.brake_n = 1'b1;
		tick(8);
		chk(drive_out, 24'h00_0007);
		pins.reset_n = 1'b0;
		tick(8);
		chk(run_out, 24'h00_0000);
		chk(drive_out, 24'h00_0000);
		pins.reset_n = 1'b1;
		tick(4);
		wr(mk(1'b1, 1'b0, 1'b1, 2'h0, 14'h3fff, 1'b0, 2'h0, 2'h0), 24);
		chk(drive_out, 24'h00_0007);
		$display("test brake done");
		rst();
		wr(mk(1'b1, 1'b0, 1'b0, 2'h0, 14'h3fff, 1'b0, 2'h0, DIAG_THERMAL), 24);
		pins.thermal = 1'b1;
		tick(6);
		chk(diag_out, 24'h00_0001);
		pins.thermal = 1'b0;
		wr(mk(1'b1, 1'b0, 1'b0, 2'h0, 14'h3fff, 1'b0, 2'h0, DIAG_ZERO_CROSS), 24);
		chk(diag_out, 24'h00_0000);
		zc(1);
		chk(diag_out, 24'h00_0001);
		$display("test diagnostic output done");
		wr(mk(1'b1, 1'b1, 1'b0, 2'h0, 14'h3fff, 1'b0, 2'h0, 2'h0), 24);
		pins.bemf_step = 1'b1;
		cnt(0, 8, nh);
		chk(nh, 24'h00_0000);
		pins.startup_step = 1'b1;
		cnt(0, 8, nh);
		chk(nh, 24'h00_0001);
		pins.bemf_step = 1'b0;
		pins.startup_step = 1'b0;
		wr(mk(1'b1, 1'b0, 1'b0, 2'h0, 14'h3fff, 1'b0, 2'h0, 2'h0), 24);
		pins.bemf_step = 1'b1;
		cnt(0, 8, nh);
		chk(nh, 24'h00_0001);
		pins.bemf_step = 1'b0;
		$display("test step mode done");
		for (int p = 0; p < 3; p++) begin
			rst();
			wr(mk(1'b1, 1'b0, 1'b0, 2'h0, 14'h3fff, 1'b0, pc[p], DIAG_TICK), 24);
			zc(np[p] - 1);
			chk(diag_out, 24'h00_0000);
			zc(1);
			chk(diag_out, 24'h00_0001);
		end
		$display("test pole count done");
		rst();
		// sector source chosen while the loop flag is low, reference count in the same word
		wr(mk(1'b1, 1'b0, 1'b0, 2'h0, 14'h3ffe, 1'b1, 2'h0, DIAG_SYNC), 24);
		chk(startup_clamp_out, 24'h00_0001);
		pins.sector = 1'b1;
		tick(40);
		chk(diag_out, 24'h00_0001);
		pins.sector = 1'b0;
		cnt(1, 20, nh);
		chk(nh, 24'h00_0001);
		chk(pump_down_out, 24'h00_0001);
		chk(startup_clamp_out, 24'h00_0000);
		tick(200);
		pins.sector = 1'b1;
		tick(300);
		chk(pump_up_out, 24'h00_0001);
		pins.sector = 1'b0;
		cnt(2, 20, nh);
		chk(nh, 24'h00_0001);
		$display("test speed loop done");
		summarize();
	end
endmodule
